// file: dv/testbench.sv
// Self-checking testbench of the watchdog reset control block
`timescale 1ns/1ps
module testbench;
  import wdr_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic ce = 1'h1;
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic [ADDR_W-1:0] wb_adr = 32'h0;
  logic [SEL_W-1:0] wb_sel = 4'h0;
  logic [DATA_W-1:0] wb_dat_i = 32'h0;
  logic [DATA_W-1:0] wb_dat_o;
  logic wb_ack, ext_out, intv, por_req, man_req;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 10762;
  logic [2:0] cks;
  logic [31:0] exp_q[$];

  always #2.5 clk = ~clk;

  wdr_watchdog_reset u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack(wb_ack), .external_overflow_output(ext_out), .interval_request(intv),
    .power_on_reset_req(por_req), .manual_reset_req(man_req));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One classic cycle; reads leave their expectation in the queue
  task automatic bus(input logic we, input logic [IDX_W-1:0] idx, input logic [31:0] dat,
                     input logic [3:0] sel, input logic [7:0] exp);
    int n;
    @(posedge clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= {2'h0, idx, 2'h0};
    wb_sel <= sel;
    wb_dat_i <= dat;
    if (!we) begin
      exp_q.push_back({24'h0, exp});
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'h1 && n < 20);
    check("ack", 32'h1, {31'h0, wb_ack});
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] key, input logic [7:0] val);
    bus(1'h1, idx, {16'h0, key, val}, SEL_HALF, 8'h00);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    bus(1'h0, idx, 32'h0, 4'h1, exp);
  endtask

  // Waits for the overflow pulse, checks reset requests and pulse length
  task automatic ovf(input logic en, input logic s);
    int n;
    n = 0;
    while (ext_out !== 1'h1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check("ext_out", 32'h1, {31'h0, ext_out});
    check("power_on_req", {31'h0, en & ~s}, {31'h0, por_req});
    check("manual_req", {31'h0, en & s}, {31'h0, man_req});
    n = 0;
    while (ext_out === 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check("pulse_len", 32'h80, 32'(n));
  endtask

  // Read data monitor
  always @(posedge clk) begin
    if (wb_ack === 1'h1 && wb_we === 1'h0) begin
      if (exp_q.size() == 0) begin
        check("read_queue", 32'h1, 32'h0);
      end else begin
        check("read_data", exp_q.pop_front(), wb_dat_o);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("mismatch timeout expected done seen running");
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    rd(IDX_CTRL_RD, 8'h00);
    rd(IDX_CNT_RD, 8'h00);
    rd(IDX_RST_RD, 8'h00);
    wr(IDX_CNT_RD, KEY_CNT, 8'h33);
    wr(IDX_RST_RD, KEY_RST_CTRL, 8'h40);
    bus(1'h1, IDX_RST_WR, {16'h0, KEY_RST_CTRL, 8'h40}, 4'hF, 8'h00);
    bus(1'h1, 28'h5FFFFBC, $random(seed), SEL_HALF, 8'h00);
    rd(28'h5FFFFBC, 8'h00);
    rd(IDX_RST_RD, 8'h00);
    cks = 3'($random(seed) & 1);
    wr(IDX_CTRL_RD, KEY_CTRL, {3'h3, 2'h0, cks});
    rd(IDX_CTRL_RD, {3'h3, 2'h0, cks});
    wr(IDX_CNT_WR, KEY_CNT, 8'hF0);
    ovf(1'h0, 1'h0);
    rd(IDX_CTRL_RD, 8'h00);
    rd(IDX_CNT_RD, 8'h00);
    wr(IDX_RST_WR, KEY_RST_FLAG, 8'h00);
    rd(IDX_RST_RD, 8'h80);
    wr(IDX_RST_WR, KEY_RST_FLAG, 8'h80);
    rd(IDX_RST_RD, 8'h80);
    wr(IDX_RST_WR, KEY_RST_FLAG, 8'h00);
    rd(IDX_RST_RD, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(IDX_RST_WR, KEY_RST_CTRL, {2'h1, 1'(s), 5'h0});
      rd(IDX_RST_RD, {2'h1, 1'(s), 5'h0});
      wr(IDX_CTRL_RD, KEY_CTRL, 8'h60);
      ovf(1'h1, 1'(s));
      rd(IDX_RST_RD, {2'h3, 1'(s), 5'h0});
      wr(IDX_RST_WR, KEY_RST_FLAG, 8'h00);
    end
    wr(IDX_CTRL_RD, KEY_CTRL, 8'h20);
    for (int n = 0; n < 1000 && intv !== 1'h1; n++) begin
      @(posedge clk);
    end
    check("interval_req", 32'h1, {31'h0, intv});
    check("ext_quiet", 32'h0, {31'h0, ext_out});
    rd(IDX_CTRL_RD, 8'hA0);
    wr(IDX_CTRL_RD, KEY_CTRL, 8'h00);
    @(posedge clk);
    check("interval_clr", 32'h0, {31'h0, intv});
    wr(IDX_CNT_WR, KEY_CNT, 8'h55);
    rd(IDX_CNT_RD, 8'h00);
    rd(IDX_RST_RD, 8'h60);
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule // testbench

// file: hdl/wdr_prescaler.sv
// Clock prescaler producing the counter input tick
`timescale 1ns/1ps
module wdr_prescaler (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic run,
  input wire logic [wdr_pkg::CKS_W-1:0] cks,
  output logic tick
);
  import wdr_pkg::*;

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [PRE_W-1:0] mask;

  assign mask = div_mask(cks);
  assign tick = run & ((pre_r & mask) == mask);
  assign pre_nxt = run ? PRE_W'(pre_r + 13'h0001) : 13'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_r <= 13'h0000;
    end else if (ce) begin
      pre_r <= pre_nxt;
    end
  end
endmodule // wdr_prescaler

// file: hdl/wdr_stretch.sv
// Holds an output high for a fixed count after a trigger
`timescale 1ns/1ps
module wdr_stretch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic trigger,
  output logic active
);
  import wdr_pkg::*;

  wdr_hold_state_type state_r;
  wdr_hold_state_type state_nxt;
  logic [HOLD_W-1:0] cnt_r;
  logic [HOLD_W-1:0] cnt_nxt;
  logic active_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (trigger) begin
          state_nxt = ST_HOLD;
          cnt_nxt = HOLD_LAST;
        end
      end
      ST_HOLD: begin
        if (cnt_r == HOLD_ZERO) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = HOLD_W'(cnt_r - HOLD_ONE);
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = HOLD_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= HOLD_ZERO;
      active_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      active_r <= (state_nxt == ST_HOLD);
    end
  end

  assign active = active_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_hold_keeps: assert property (ce && active_r && cnt_r != HOLD_ZERO |=> active_r)
    else $error("stretched output dropped early");
  a_hold_ends: assert property ($fell(active_r) && !$past(sys_rst) |-> $past(cnt_r) == HOLD_ZERO)
    else $error("stretched output fell before count ran out");
endmodule // wdr_stretch

// file: hdl/wdr_watchdog_reset.sv
// Watchdog counter, control and overflow reset generation with Wishbone slave
`timescale 1ns/1ps
module wdr_watchdog_reset (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [wdr_pkg::ADDR_W-1:0] wb_adr,
  input wire logic [wdr_pkg::SEL_W-1:0] wb_sel,
  input wire logic [wdr_pkg::DATA_W-1:0] wb_dat_i,
  output logic [wdr_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack,
  output logic external_overflow_output,
  output logic interval_request,
  output logic power_on_reset_req,
  output logic manual_reset_req
);
  import wdr_pkg::*;

  logic ack_r;
  logic [DATA_W-1:0] dat_r;
  logic [DATA_W-1:0] dat_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic ovf_seen_r;
  logic ovf_seen_nxt;
  logic mode_r;
  logic mode_nxt;
  logic run_r;
  logic run_nxt;
  logic [CKS_W-1:0] cks_r;
  logic [CKS_W-1:0] cks_nxt;
  logic watchdog_overflow_flag_r;
  logic watchdog_overflow_flag_nxt;
  logic watchdog_overflow_flag_seen_r;
  logic watchdog_overflow_flag_seen_nxt;
  logic overflow_reset_enable_r;
  logic overflow_reset_enable_nxt;
  logic reset_type_select_r;
  logic reset_type_select_nxt;
  logic type_r;
  logic type_nxt;

  // Bus decode
  wire req = wb_cyc & wb_stb & ~ack_r;
  wire wr = req & wb_we & (wb_sel == SEL_HALF);
  wire rd = req & ~wb_we;
  wire [7:0] key = wb_dat_i[15:8];
  wire [7:0] lo = wb_dat_i[7:0];
  wire hit_cnt_wr = addr_hit(wb_adr, IDX_CNT_WR);
  wire hit_rst_wr = addr_hit(wb_adr, IDX_RST_WR);
  wire wr_cnt = wr & hit_cnt_wr & (key == KEY_CNT);
  wire wr_ctl = wr & hit_cnt_wr & (key == KEY_CTRL);
  wire wr_rflag = wr & hit_rst_wr & (key == KEY_RST_FLAG);
  wire wr_rctl = wr & hit_rst_wr & (key == KEY_RST_CTRL);
  wire rd_ctl = rd & addr_hit(wb_adr, IDX_CTRL_RD);
  wire rd_cnt = rd & addr_hit(wb_adr, IDX_CNT_RD);
  wire rd_rst = rd & addr_hit(wb_adr, IDX_RST_RD);

  // Register views
  wire [7:0] ctl_view = {ovf_r, mode_r, run_r, 2'b00, cks_r};
  wire [7:0] rst_view = {watchdog_overflow_flag_r, overflow_reset_enable_r, reset_type_select_r, 5'b00000};

  // Counting and overflow events
  logic tick;
  wire wrap = run_r & tick & ~wr_cnt & (cnt_r == CNT_MAX);
  wire wdt_ovf = wrap & mode_r;
  wire itv_ovf = wrap & ~mode_r;
  logic rst_active;

  wdr_prescaler u_prescaler (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run(run_r),
    .cks(cks_r),
    .tick(tick)
  );

  wdr_stretch u_out_stretch (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .trigger(wdt_ovf),
    .active(external_overflow_output)
  );

  wdr_stretch u_rst_stretch (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .trigger(wdt_ovf & overflow_reset_enable_r),
    .active(rst_active)
  );

  // Counter
  always_comb begin
    cnt_nxt = cnt_r;
    if (!run_r || wdt_ovf) begin
      cnt_nxt = CNT_ZERO;
    end else if (wr_cnt) begin
      cnt_nxt = lo;
    end else if (tick) begin
      cnt_nxt = CNT_W'(cnt_r + CNT_ONE);
    end
  end

  // Timer control register
  always_comb begin
    mode_nxt = mode_r;
    run_nxt = run_r;
    cks_nxt = cks_r;
    if (wdt_ovf) begin
      mode_nxt = 1'b0;
      run_nxt = 1'b0;
      cks_nxt = CKS_INIT;
    end else if (wr_ctl) begin
      mode_nxt = lo[CTL_MODE_BIT];
      run_nxt = lo[CTL_RUN_BIT];
      cks_nxt = lo[CKS_W-1:0];
    end
  end

  // Interval flag: set wins over clear
  assign ovf_nxt = itv_ovf | (ovf_r & ~(wr_ctl & ~lo[CTL_OVF_BIT] & ovf_seen_r) & ~wdt_ovf);
  assign ovf_seen_nxt = (rd_ctl & ovf_r) | (ovf_seen_r & ~wr_ctl & ~wdt_ovf);

  // Watchdog flag: set wins over clear
  assign watchdog_overflow_flag_nxt = wdt_ovf | (watchdog_overflow_flag_r & ~(wr_rflag & ~lo[RST_WATCHDOG_OVERFLOW_FLAG_BIT] & watchdog_overflow_flag_seen_r));
  assign watchdog_overflow_flag_seen_nxt = (rd_rst & watchdog_overflow_flag_r) | (watchdog_overflow_flag_seen_r & ~wr_rflag);
  assign overflow_reset_enable_nxt = wr_rctl ? lo[RST_ENA_BIT] : overflow_reset_enable_r;
  assign reset_type_select_nxt = wr_rctl ? lo[RST_SEL_BIT] : reset_type_select_r;
  assign type_nxt = (wdt_ovf & overflow_reset_enable_r & ~rst_active) ? reset_type_select_r : type_r;

  // Read data, unmapped reads return zero
  always_comb begin
    dat_nxt = dat_r;
    if (req) begin
      dat_nxt = '0;
      if (rd_ctl) begin
        dat_nxt[7:0] = ctl_view;
      end else if (rd_cnt) begin
        dat_nxt[7:0] = cnt_r;
      end else if (rd_rst) begin
        dat_nxt[7:0] = rst_view;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      dat_r <= '0;
      cnt_r <= CNT_ZERO;
      ovf_r <= 1'b0;
      ovf_seen_r <= 1'b0;
      mode_r <= 1'b0;
      run_r <= 1'b0;
      cks_r <= CKS_INIT;
      watchdog_overflow_flag_r <= 1'b0;
      watchdog_overflow_flag_seen_r <= 1'b0;
      overflow_reset_enable_r <= 1'b0;
      reset_type_select_r <= 1'b0;
      type_r <= 1'b0;
    end else if (ce) begin
      ack_r <= req;
      dat_r <= dat_nxt;
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
      ovf_seen_r <= ovf_seen_nxt;
      mode_r <= mode_nxt;
      run_r <= run_nxt;
      cks_r <= cks_nxt;
      watchdog_overflow_flag_r <= watchdog_overflow_flag_nxt;
      watchdog_overflow_flag_seen_r <= watchdog_overflow_flag_seen_nxt;
      overflow_reset_enable_r <= overflow_reset_enable_nxt;
      reset_type_select_r <= reset_type_select_nxt;
      type_r <= type_nxt;
    end
  end

  assign wb_ack = ack_r;
  assign wb_dat_o = dat_r;
  assign interval_request = ovf_r & ~mode_r;
  assign power_on_reset_req = rst_active & ~type_r;
  assign manual_reset_req = rst_active & type_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Overflow output and internal reset
  a_rst_with_out: assert property ($rose(rst_active) |-> $rose(external_overflow_output))
    else $error("internal reset not aligned with overflow output");

  a_rst_needs_ena: assert property ($rose(rst_active) |-> $past(overflow_reset_enable_r))
    else $error("internal reset raised without reset enable");

  a_no_rst: assert property (ce && wdt_ovf && !overflow_reset_enable_r && !rst_active |=> !rst_active)
    else $error("internal reset raised while disabled");

  a_rst_kind: assert property (ce && wdt_ovf && overflow_reset_enable_r && !rst_active |=>
      manual_reset_req == $past(reset_type_select_r) && power_on_reset_req == !$past(reset_type_select_r))
    else $error("wrong internal reset type");

  a_kind_single: assert property (!(power_on_reset_req && manual_reset_req))
    else $error("both reset kinds requested");

  a_out_on_ovf: assert property (ce && wdt_ovf && !external_overflow_output |=>
      external_overflow_output)
    else $error("watchdog overflow did not raise output");

  a_itv_no_out: assert property (ce && itv_ovf && !external_overflow_output |=>
      !external_overflow_output)
    else $error("interval overflow raised watchdog output");

  a_itv_req: assert property (ce && itv_ovf |=> interval_request ##0 !external_overflow_output)
    else $error("interval overflow did not request interrupt");

  // Counter
  a_cnt_step: assert property (ce && run_r && tick && !wr_cnt && !wdt_ovf |=>
      cnt_r == CNT_W'($past(cnt_r) + CNT_ONE))
    else $error("counter did not advance on tick");

  a_cnt_write: assert property (ce && wr_cnt && run_r |=>
      cnt_r == $past(lo))
    else $error("counter write did not land");

  a_cnt_read: assert property (ce && rd_cnt |=> wb_ack && wb_dat_o[7:0] == $past(cnt_r))
    else $error("counter read returned wrong value");

  a_wdt_reinit: assert property (ce && wdt_ovf |=> !run_r && !mode_r && cnt_r == CNT_ZERO)
    else $error("overflow did not reinitialise timer");

  a_stop_zero: assert property (ce && !run_r |=> cnt_r == CNT_ZERO)
    else $error("stopped counter not held at zero");

  a_wrap_event: assert property (ce && wrap |=> cnt_r == CNT_ZERO)
    else $error("overflow without wrap to zero");

  // Reset control register and flag
  a_rst_read: assert property (ce && rd_rst |=> wb_ack && wb_dat_o[7:0] == $past(rst_view))
    else $error("reset control read returned wrong value");

  a_rctl_write: assert property (ce && wr_rctl |=>
      overflow_reset_enable_r == $past(lo[RST_ENA_BIT]) && reset_type_select_r == $past(lo[RST_SEL_BIT]))
    else $error("reset control write did not land");

  a_half_only: assert property (ce && req && wb_we && wb_sel != SEL_HALF |=>
      $stable(overflow_reset_enable_r) && $stable(reset_type_select_r) && $stable(watchdog_overflow_flag_r))
    else $error("write with wrong width took effect");

  a_watchdog_overflow_flag_set: assert property (ce && wdt_ovf |=> watchdog_overflow_flag_r)
    else $error("watchdog flag not set on overflow");

  a_watchdog_overflow_flag_itv: assert property (ce && itv_ovf && !watchdog_overflow_flag_r |=> !watchdog_overflow_flag_r)
    else $error("watchdog flag set by interval overflow");

  a_watchdog_overflow_flag_guard: assert property (ce && watchdog_overflow_flag_r && !watchdog_overflow_flag_seen_r |=> watchdog_overflow_flag_r)
    else $error("watchdog flag cleared without prior read");

  a_watchdog_overflow_flag_clear: assert property (ce && wr_rflag && !lo[RST_WATCHDOG_OVERFLOW_FLAG_BIT] && watchdog_overflow_flag_seen_r && !wdt_ovf |=>
      !watchdog_overflow_flag_r)
    else $error("watchdog flag not cleared after read");

  a_watchdog_overflow_flag_one: assert property (ce && wr_rflag && lo[RST_WATCHDOG_OVERFLOW_FLAG_BIT] && watchdog_overflow_flag_r |=>
      watchdog_overflow_flag_r)
    else $error("watchdog flag cleared by writing one");

  // Bus handshake and clock enable
  a_ack_answer: assert property (ce && req |=> wb_ack)
    else $error("request not acknowledged in next cycle");

  a_ack_pulse: assert property (ce && wb_ack |=> !wb_ack)
    else $error("acknowledge held longer than one cycle");

  a_ce_freeze: assert property (!ce |=>
      $stable(cnt_r) && $stable(watchdog_overflow_flag_r) && $stable(wb_ack) && $stable(wb_dat_o))
    else $error("state changed while clock enable low");

  c_wdt_reset: cover property (ce && wdt_ovf && overflow_reset_enable_r);
  c_itv_ovf: cover property (ce && itv_ovf);
  c_watchdog_overflow_flag_clear: cover property (watchdog_overflow_flag_r ##1 !watchdog_overflow_flag_r);
  c_manual: cover property ($rose(manual_reset_req));
  c_refused_wr: cover property (ce && req && wb_we && !wr);
endmodule // wdr_watchdog_reset

// file: include/wdr_pkg.sv
// Constants, types and helpers of the watchdog reset control block
// What this block does
// - Internal reset starts with external overflow output
// - Counter is eight bits, counts selected clock
// - Counter read odd address, written even
// - Reset control read odd address, written even
// - Watchdog-mode overflow sets overflow flag
// - Flag clears only on write zero after read
// - Reset enable zero gives no internal reset
// - Select bit picks power-on or manual reset
// - Watchdog-mode overflow reinitialises counter and control register
// - Mode one drives output, zero requests interrupt
// - Enable zero holds counter at zero
package wdr_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int SEL_W = 4;
  localparam int IDX_W = 28;
  localparam logic [IDX_W-1:0] IDX_CTRL_RD = 28'h5FFFFB8;
  localparam logic [IDX_W-1:0] IDX_CNT_WR = 28'h5FFFFB8;
  localparam logic [IDX_W-1:0] IDX_CNT_RD = 28'h5FFFFB9;
  localparam logic [IDX_W-1:0] IDX_RST_WR = 28'h5FFFFBA;
  localparam logic [IDX_W-1:0] IDX_RST_RD = 28'h5FFFFBB;
  localparam logic [SEL_W-1:0] SEL_HALF = 4'h3;
  localparam logic [7:0] KEY_CNT = 8'h5A;
  localparam logic [7:0] KEY_CTRL = 8'hA5;
  localparam logic [7:0] KEY_RST_FLAG = 8'hA5;
  localparam logic [7:0] KEY_RST_CTRL = 8'h5A;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam int CTL_OVF_BIT = 7;
  localparam int CTL_MODE_BIT = 6;
  localparam int CTL_RUN_BIT = 5;
  localparam int CKS_W = 3;
  localparam logic [CKS_W-1:0] CKS_INIT = 3'h0;
  localparam int RST_WATCHDOG_OVERFLOW_FLAG_BIT = 7;
  localparam int RST_ENA_BIT = 6;
  localparam int RST_SEL_BIT = 5;
  localparam int PRE_W = 13;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RST_PULSE_NS = 640;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RST_PULSE_CYC - 1);
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 8'h00;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 8'h01;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_HOLD = 1'b1
  } wdr_hold_state_type;

  // Byte address is four times the register index
  function automatic logic addr_hit(input logic [ADDR_W-1:0] adr, input logic [IDX_W-1:0] idx);
    addr_hit = (adr[ADDR_W-1:2] == {2'b00, idx});
  endfunction

  // Prescaler mask: divisor minus one per clock select
  function automatic logic [PRE_W-1:0] div_mask(input logic [CKS_W-1:0] cks);
    case (cks)
      3'h0: div_mask = 13'h0001;
      3'h1: div_mask = 13'h003F;
      3'h2: div_mask = 13'h007F;
      3'h3: div_mask = 13'h00FF;
      3'h4: div_mask = 13'h01FF;
      3'h5: div_mask = 13'h03FF;
      3'h6: div_mask = 13'h0FFF;
      default: div_mask = 13'h1FFF;
    endcase
  endfunction
endpackage
